// ### hdl/ctf_cfg.svh
// constants for the control timer flag and status block
// assumes a 32-bit classic wishbone register bus
`ifndef CTF_CFG_SVH
`define CTF_CFG_SVH
`define CTF_OFS_FLAGS    8'h2c
`define CTF_OFS_STATUS   8'h30
`define CTF_OFS_CTRL     8'h40
`define CTF_OFS_CHVAL0   8'h44
`define CTF_OFS_CHBUF0   8'h54
`define CTF_OFS_PERBUF   8'h64
`define CTF_OFS_WAVEBUF  8'h68
`define CTF_OFS_PATTBUF  8'h6c
`define CTF_STATUS_RST   32'h0000_0001
`define CTF_FLAG_MASK    32'h000f_f80f
`define CTF_STAT_W1C     32'h000f_f0e8
`define CTF_B_HIT        16
`define CTF_B_NRF        14
`define CTF_B_RFB        13
`define CTF_B_RFA        12
`define CTF_B_DBG        11
`define CTF_B_ERR        3
`define CTF_B_CNT        2
`define CTF_B_TRG        1
`define CTF_B_WRAP       0
`define CTF_S_CMP        24
`define CTF_S_CHBV       16
`define CTF_S_NRF        14
`define CTF_S_RFB        13
`define CTF_S_RFA        12
`define CTF_S_IN         8
`define CTF_S_PERIOD_BUFFER_VALID      7
`define CTF_S_WAVEFORM_BUFFER_VALID     6
`define CTF_S_PATTERN_BUFFER_VALID     5
`define CTF_S_DBG        3
`define CTF_S_IDX        1
`define CTF_S_STOP       0
`define CTF_C_CAPMODE    0
`define CTF_C_LOCKUPD    4
`define CTF_C_RAMP       5
`define CTF_C_SINGLESHOT 7
`define CTF_C_DBGDET     8
`define CTF_C_SWHALT_A   9
`define CTF_C_SWHALT_B   10
`define CTF_C_NRE        16
`define CTF_C_NRV        20
`endif

// ### hdl/ctf_pkg.sv
// types for the control timer flag and status block
// assumes ctf_cfg.svh holds the numeric constants
package ctf_pkg;
  typedef enum logic [1:0] {
    CTF_RAMP_SINGLE  = 2'h0,
    CTF_RAMP_ALT_TWO = 2'h1,
    CTF_RAMP_TWO     = 2'h2,
    CTF_RAMP_RSVD    = 2'h3
  } ctf_ramp_t;
endpackage : ctf_pkg

// ### hdl/ctf_flags_status.sv
// flag and status logic of a 24-bit control timer, wishbone slave
// assumes core signals are synchronous to sys_clk, fault pins are raw pins
`timescale 1ns/1ps
`default_nettype none
`include "ctf_cfg.svh"

module ctf_flags_status
  import ctf_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // counter core, same clock
  input  wire logic        tick_clock,
  input  wire logic [3:0]  match_evt,
  input  wire logic [3:0]  capture_evt,
  input  wire logic [23:0] capture_val,
  input  wire logic        counter_evt,
  input  wire logic        retrigger_evt,
  input  wire logic        wrap_evt,
  input  wire logic        update_evt,
  input  wire logic        stop_cmd,
  input  wire logic        count_step,
  input  wire logic        ramp_cycle_b,
  input  wire logic [3:0]  compare_output_level,
  input  wire logic        recov_resume_a,
  input  wire logic        recov_resume_b,
  input  wire logic        debug_mode,
  // fault pins, asynchronous
  input  wire logic        recov_input_a,
  input  wire logic        recov_input_b,
  input  wire logic        nonrecov_input_zero,
  input  wire logic        nonrecov_input_one,
  // to counter core and waveform output stage
  output logic             counter_halt,
  output logic [3:0]       wave_force_en,
  output logic [3:0]       wave_force_val
);

  // -------------------------------------------------------------
  // fault pin synchronisers
  // -------------------------------------------------------------
  logic [3:0] fin_meta_q;
  logic [3:0] fin_q; // {nr1, nr0, b, a}

  // two-stage sync of fault pins
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      fin_meta_q <= 4'h0;
      fin_q      <= 4'h0;
    end else begin
      fin_meta_q <= {nonrecov_input_one, nonrecov_input_zero, recov_input_b, recov_input_a};
      fin_q      <= fin_meta_q;
    end
  end

  logic [3:0] fin_d1_q;
  logic [3:0] fin_rise;

  // fault occurrence is the rising edge of the synced input
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      fin_d1_q <= 4'h0;
    end else begin
      fin_d1_q <= fin_q;
    end
  end

  assign fin_rise = fin_q & ~fin_d1_q;

  // -------------------------------------------------------------
  // bus decode
  // -------------------------------------------------------------
  logic        acc;
  logic        wr;
  logic        rd;
  logic [31:0] wmask;
  logic [31:0] wdat;

  // byte-lane write mask
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction : lane_mask

  // address hit of a word register
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr[7:2] == ofs[7:2]);
  endfunction : hit

  assign acc   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr    = acc & wb_we_i;
  assign rd    = acc & ~wb_we_i;
  assign wmask = lane_mask(wb_sel_i);
  assign wdat  = wb_dat_i & wmask;

  logic       wr_flags;
  logic       wr_status;
  logic       wr_ctrl;
  logic [3:0] wr_chbuf;
  logic [3:0] rd_chval;
  logic       wr_perbuf;
  logic       wr_wavebuf;
  logic       wr_pattbuf;

  // register selects, one per channel for value and buffer
  always_comb begin
    wr_flags   = wr & hit(wb_adr_i, `CTF_OFS_FLAGS);
    wr_status  = wr & hit(wb_adr_i, `CTF_OFS_STATUS);
    wr_ctrl    = wr & hit(wb_adr_i, `CTF_OFS_CTRL);
    wr_perbuf  = wr & hit(wb_adr_i, `CTF_OFS_PERBUF);
    wr_wavebuf = wr & hit(wb_adr_i, `CTF_OFS_WAVEBUF);
    wr_pattbuf = wr & hit(wb_adr_i, `CTF_OFS_PATTBUF);
    for (int i = 0; i < 4; i++) begin
      wr_chbuf[i] = wr & hit(wb_adr_i, `CTF_OFS_CHBUF0 + 8'(4 * i));
      rd_chval[i] = rd & hit(wb_adr_i, `CTF_OFS_CHVAL0 + 8'(4 * i));
    end
  end

  // -------------------------------------------------------------
  // control register
  // -------------------------------------------------------------
  logic [23:0] ctrl_q;
  logic [3:0]  capture_mode;
  logic        lock_update;
  ctf_ramp_t   ramp_mode;
  logic        single_shot;
  logic        debug_fault_detect_enable;
  logic        swhalt_a;
  logic        swhalt_b;
  logic [3:0]  nonrecov_output_enable;
  logic [3:0]  nonrecov_output_value;

  // configuration written by software
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ctrl_q <= 24'h00_0000;
    end else if (wr_ctrl) begin
      ctrl_q <= (ctrl_q & ~wmask[23:0]) | wdat[23:0];
    end
  end

  assign capture_mode              = ctrl_q[`CTF_C_CAPMODE +: 4];
  assign lock_update               = ctrl_q[`CTF_C_LOCKUPD];
  assign ramp_mode                 = ctf_ramp_t'(ctrl_q[`CTF_C_RAMP +: 2]);
  assign single_shot               = ctrl_q[`CTF_C_SINGLESHOT];
  assign debug_fault_detect_enable = ctrl_q[`CTF_C_DBGDET];
  assign swhalt_a                  = ctrl_q[`CTF_C_SWHALT_A];
  assign swhalt_b                  = ctrl_q[`CTF_C_SWHALT_B];
  assign nonrecov_output_enable    = ctrl_q[`CTF_C_NRE +: 4];
  assign nonrecov_output_value     = ctrl_q[`CTF_C_NRV +: 4];

  // -------------------------------------------------------------
  // channel value and buffer storage
  // -------------------------------------------------------------
  logic [23:0] chval_q [4];
  logic [23:0] chbuf_q [4];
  logic [23:0] perbuf_q;
  logic [23:0] wavebuf_q;
  logic [23:0] pattbuf_q;

  // capture lands in value register, compare buffers written by software
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      for (int i = 0; i < 4; i++) begin
        chval_q[i] <= 24'h00_0000;
        chbuf_q[i] <= 24'h00_0000;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (capture_mode[i] && capture_evt[i]) begin
          chbuf_q[i] <= capture_val;
          chval_q[i] <= capture_val;
        end else if (wr_chbuf[i]) begin
          chbuf_q[i] <= wdat[23:0];
        end else if (!capture_mode[i] && update_evt) begin
          chval_q[i] <= chbuf_q[i];
        end
      end
    end
  end

  // period, waveform and pattern buffers
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      perbuf_q  <= 24'h00_0000;
      wavebuf_q <= 24'h00_0000;
      pattbuf_q <= 24'h00_0000;
    end else begin
      if (wr_perbuf)  perbuf_q  <= wdat[23:0];
      if (wr_wavebuf) wavebuf_q <= wdat[23:0];
      if (wr_pattbuf) pattbuf_q <= wdat[23:0];
    end
  end

  // -------------------------------------------------------------
  // state bits of the status register
  // -------------------------------------------------------------
  logic [31:0] w1c_stat;
  logic [3:0]  chbv_q;
  logic [1:0]  nrf_state_q;
  logic        rfa_state_q;
  logic        rfb_state_q;
  logic        period_buffer_valid_q;
  logic        waveform_buffer_valid_q;
  logic        pattern_buffer_valid_q;
  logic        dbg_state_q;
  logic        stop_q;
  logic [3:0]  dbg_rise;

  assign w1c_stat = wr_status ? (wdat & `CTF_STAT_W1C) : 32'h0000_0000;

  // channel buffer valid; set wins over clear
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      chbv_q <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (capture_mode[i]) begin
          if (capture_evt[i])  chbv_q[i] <= 1'b1;
          else if (rd_chval[i]) chbv_q[i] <= 1'b0;
        end else begin
          if (wr_chbuf[i]) chbv_q[i] <= 1'b1;
          else if (update_evt || (lock_update && w1c_stat[`CTF_S_CHBV + i]))
            chbv_q[i] <= 1'b0;
        end
      end
    end
  end

  // period, waveform, pattern buffer valid
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      period_buffer_valid_q  <= 1'b0;
      waveform_buffer_valid_q <= 1'b0;
      pattern_buffer_valid_q <= 1'b0;
    end else begin
      if (wr_perbuf) period_buffer_valid_q <= 1'b1;
      else if ((update_evt && lock_update) || w1c_stat[`CTF_S_PERIOD_BUFFER_VALID]) period_buffer_valid_q <= 1'b0;
      if (wr_wavebuf) waveform_buffer_valid_q <= 1'b1;
      else if ((update_evt && lock_update) || w1c_stat[`CTF_S_WAVEFORM_BUFFER_VALID]) waveform_buffer_valid_q <= 1'b0;
      if (wr_pattbuf) pattern_buffer_valid_q <= 1'b1;
      else if ((update_evt && lock_update) || w1c_stat[`CTF_S_PATTERN_BUFFER_VALID]) pattern_buffer_valid_q <= 1'b0;
    end
  end

  // fault states; clearing resumes from last count, restart is software's job
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      nrf_state_q <= 2'h0;
      rfa_state_q <= 1'b0;
      rfb_state_q <= 1'b0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (fin_q[2 + i]) nrf_state_q[i] <= 1'b1;
        else if (w1c_stat[`CTF_S_NRF + i]) nrf_state_q[i] <= 1'b0;
      end
      if (fin_q[0]) rfa_state_q <= 1'b1;
      else if (recov_resume_a || w1c_stat[`CTF_S_RFA]) rfa_state_q <= 1'b0;
      if (fin_q[1]) rfb_state_q <= 1'b1;
      else if (recov_resume_b || w1c_stat[`CTF_S_RFB]) rfb_state_q <= 1'b0;
    end
  end

  // debug fault state and stopped bit
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      dbg_state_q <= 1'b0;
      stop_q      <= 1'b1;
    end else begin
      if (debug_mode && debug_fault_detect_enable) dbg_state_q <= 1'b1;
      else if (!debug_mode && w1c_stat[`CTF_S_DBG]) dbg_state_q <= 1'b0;
      if (stop_cmd || (update_evt && single_shot)) stop_q <= 1'b1;
      else if (count_step) stop_q <= 1'b0;
    end
  end

  // -------------------------------------------------------------
  // event capture and interrupt flags
  // -------------------------------------------------------------
  logic [31:0] pend_q;
  logic [31:0] pend_now;
  logic [31:0] flags_q;
  logic [31:0] set_now;
  logic [31:0] clr_now;
  logic        dbg_state_d1_q;

  always_ff @(posedge sys_clk) begin
    if (!resetn) dbg_state_d1_q <= 1'b0;
    else dbg_state_d1_q <= dbg_state_q;
  end

  assign dbg_rise = {3'h0, dbg_state_q & ~dbg_state_d1_q};

  // collect events now; they land in flags on the next tick
  always_comb begin
    pend_now = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      pend_now[`CTF_B_HIT + i] = (!capture_mode[i] && match_evt[i]) ||
                                 (capture_mode[i] && capture_evt[i]);
    end
    pend_now[`CTF_B_NRF +: 2] = fin_rise[3:2];
    pend_now[`CTF_B_RFB]      = fin_rise[1];
    pend_now[`CTF_B_RFA]      = fin_rise[0];
    pend_now[`CTF_B_DBG]      = dbg_rise[0];
    pend_now[`CTF_B_CNT]      = counter_evt;
    pend_now[`CTF_B_TRG]      = retrigger_evt;
    pend_now[`CTF_B_WRAP]     = wrap_evt;
  end

  // pending events wait for the next tick
  always_ff @(posedge sys_clk) begin
    if (!resetn) pend_q <= 32'h0000_0000;
    else if (tick_clock) pend_q <= pend_now;
    else pend_q <= pend_q | pend_now;
  end

  // flags set on tick, error set at once on overrun capture
  always_comb begin
    set_now = tick_clock ? pend_q : 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      if (capture_mode[i] && capture_evt[i] && flags_q[`CTF_B_HIT + i])
        set_now[`CTF_B_ERR] = 1'b1;
    end
    clr_now = wr_flags ? (wdat & `CTF_FLAG_MASK) : 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      if (capture_mode[i] && rd_chval[i]) clr_now[`CTF_B_HIT + i] = 1'b1;
    end
  end

  // set wins over clear
  always_ff @(posedge sys_clk) begin
    if (!resetn) flags_q <= 32'h0000_0000;
    else flags_q <= ((flags_q & ~clr_now) | set_now) & `CTF_FLAG_MASK;
  end

  // -------------------------------------------------------------
  // status word, halt and forced outputs
  // -------------------------------------------------------------
  logic [31:0] status_word;
  logic        ramp_idx;

  assign ramp_idx = (ramp_mode == CTF_RAMP_TWO || ramp_mode == CTF_RAMP_ALT_TWO) ? ramp_cycle_b : 1'b0;

  // status read value
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`CTF_S_CMP +: 4]  = compare_output_level;
    status_word[`CTF_S_CHBV +: 4] = chbv_q;
    status_word[`CTF_S_NRF +: 2]  = nrf_state_q;
    status_word[`CTF_S_RFB]       = rfb_state_q;
    status_word[`CTF_S_RFA]       = rfa_state_q;
    status_word[`CTF_S_IN +: 4]   = fin_q;
    status_word[`CTF_S_PERIOD_BUFFER_VALID]     = period_buffer_valid_q;
    status_word[`CTF_S_WAVEFORM_BUFFER_VALID]    = waveform_buffer_valid_q;
    status_word[`CTF_S_PATTERN_BUFFER_VALID]    = pattern_buffer_valid_q;
    status_word[`CTF_S_DBG]       = dbg_state_q;
    status_word[`CTF_S_IDX]       = ramp_idx;
    status_word[`CTF_S_STOP]      = stop_q;
  end

  // halt while any fault holds the timer or debug state is set
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      counter_halt   <= 1'b0;
      wave_force_en  <= 4'h0;
      wave_force_val <= 4'h0;
    end else begin
      counter_halt   <= dbg_state_q | (|nrf_state_q) |
                        (rfa_state_q & swhalt_a) | (rfb_state_q & swhalt_b);
      wave_force_en  <= (dbg_state_q | (|nrf_state_q)) ? nonrecov_output_enable : 4'h0;
      wave_force_val <= nonrecov_output_value;
    end
  end

  // -------------------------------------------------------------
  // wishbone answer, one wait state
  // -------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= acc;
      wb_dat_o <= 32'h0000_0000;
      if (rd) begin
        if (hit(wb_adr_i, `CTF_OFS_FLAGS)) wb_dat_o <= flags_q;
        else if (hit(wb_adr_i, `CTF_OFS_STATUS)) wb_dat_o <= status_word;
        else if (hit(wb_adr_i, `CTF_OFS_CTRL)) wb_dat_o <= {8'h00, ctrl_q};
        else if (hit(wb_adr_i, `CTF_OFS_PERBUF)) wb_dat_o <= {8'h00, perbuf_q};
        else if (hit(wb_adr_i, `CTF_OFS_WAVEBUF)) wb_dat_o <= {8'h00, wavebuf_q};
        else if (hit(wb_adr_i, `CTF_OFS_PATTBUF)) wb_dat_o <= {8'h00, pattbuf_q};
        for (int i = 0; i < 4; i++) begin
          if (rd_chval[i]) wb_dat_o <= {8'h00, chval_q[i]};
          if (hit(wb_adr_i, `CTF_OFS_CHBUF0 + 8'(4 * i))) wb_dat_o <= {8'h00, chbuf_q[i]};
        end
      end
    end
  end

endmodule : ctf_flags_status
`default_nettype wire

// ### test/ctf_flags_status_properties.sv
// port assertions for the control timer flag and status block
// assumes a bind into ctf_flags_status placed in the testbench
`timescale 1ns/1ps
`default_nettype none
`include "ctf_cfg.svh"
module ctf_flags_status_chk (
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        ramp_cycle_b,
  input wire logic [3:0]  compare_output_level,
  input wire logic        recov_input_a,
  input wire logic        recov_input_b,
  input wire logic        nonrecov_input_zero,
  input wire logic        nonrecov_input_one
);
  // ------------------------------
  // helper logic
  // ------------------------------
  logic [8:0] pin_d;
  logic [8:0] pin_q;
  logic [2:0] calm_q;
  logic       rd_ack;
  logic       rd_st;
  logic       mapped;
  // levels mirrored in status, and read acks by place
  assign pin_d  = {ramp_cycle_b, compare_output_level, nonrecov_input_one, nonrecov_input_zero, recov_input_b,
                   recov_input_a};
  assign rd_ack = wb_ack_o && !wb_we_i;
  assign rd_st  = rd_ack && wb_adr_i == `CTF_OFS_STATUS;
  assign mapped = wb_adr_i == `CTF_OFS_FLAGS || wb_adr_i == `CTF_OFS_STATUS || wb_adr_i == `CTF_OFS_CTRL ||
                  (wb_adr_i >= `CTF_OFS_CHVAL0 && wb_adr_i <= `CTF_OFS_PATTBUF);
  // cycles the mirrored levels held still, saturating
  always_ff @(posedge sys_clk) begin
    pin_q <= pin_d;
    if (!resetn || pin_d != pin_q) begin
      calm_q <= 3'h0;
    end else if (calm_q != 3'h7) begin
      calm_q <= calm_q + 3'h1;
    end
  end
  // ------------------------------
  // assertions
  // ------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  ack_follows_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  unmapped_zero_a: assert property (rd_ack && !mapped && wb_adr_i[1:0] == 2'h0 |-> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  flag_spare_a: assert property (rd_ack && wb_adr_i == `CTF_OFS_FLAGS |-> (wb_dat_o & ~`CTF_FLAG_MASK) == 32'h0)
    else $error("spare flag bit set");
  status_spare_a: assert property (rd_st |-> (wb_dat_o & 32'hf0f0_0014) == 32'h0)
    else $error("spare status bit set");
  input_mirror_a: assert property (rd_st && calm_q == 3'h7 |-> wb_dat_o[11:8] == pin_d[3:0])
    else $error("fault input bits differ from pins");
  cmp_mirror_a: assert property (rd_st && calm_q == 3'h7 |-> wb_dat_o[27:24] == compare_output_level)
    else $error("compare level bits differ");
  ramp_low_a: assert property (rd_st && calm_q == 3'h7 && !ramp_cycle_b |-> !wb_dat_o[1])
    else $error("ramp bit high outside cycle b");
endmodule : ctf_flags_status_chk
`default_nettype wire

// ### test/testbench.sv
// self-checking testbench for the control timer flag and status block
// assumes design, package and checker files are compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "ctf_cfg.svh"
module testbench
  import ctf_pkg::*;
;
  logic        sys_clk     = 1'b0;
  logic        resetn      = 1'b0;
  logic        wb_cyc_i    = 1'b0;
  logic        wb_stb_i    = 1'b0;
  logic        wb_we_i     = 1'b0;
  logic [7:0]  wb_adr_i    = 8'h00;
  logic [31:0] wb_dat_i    = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [16:0] ev          = 17'h0_0000;
  logic [23:0] capture_val = 24'h00_0000;
  logic [3:0]  pins        = 4'h0;
  logic [3:0]  cmp         = 4'h0;
  logic        ramp_b      = 1'b0;
  logic        dbg         = 1'b0;
  logic        counter_halt;
  logic [3:0]  wave_force_en;
  logic [3:0]  wave_force_val;
  int          n_mismatch  = 0;
  int          n_compared  = 0;
  ctf_flags_status u_ctf_flags_status (
    .sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .tick_clock(ev[16]), .match_evt(ev[3:0]), .capture_evt(ev[7:4]), .capture_val(capture_val),
    .counter_evt(ev[8]), .retrigger_evt(ev[9]), .wrap_evt(ev[10]), .update_evt(ev[11]), .stop_cmd(ev[12]),
    .count_step(ev[13]), .ramp_cycle_b(ramp_b), .compare_output_level(cmp), .recov_resume_a(ev[14]),
    .recov_resume_b(ev[15]), .debug_mode(dbg), .recov_input_a(pins[0]), .recov_input_b(pins[1]),
    .nonrecov_input_zero(pins[2]), .nonrecov_input_one(pins[3]), .counter_halt(counter_halt),
    .wave_force_en(wave_force_en), .wave_force_val(wave_force_val)
  );
  // ------------------------------
  // shared tasks
  // ------------------------------
  always #12.5 sys_clk = ~sys_clk;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic end_of_test;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test
  // one classic cycle held until ack, bounded
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    for (i = 0; i < 16 && wb_ack_o !== 1'b1; i++) @(posedge sys_clk);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (i == 16) begin
      chk("bus ack", 32'h0, 32'h1);
      end_of_test();
    end
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask : rd
  task automatic pulse(input int k);
    @(posedge sys_clk);
    ev[k] <= 1'b1;
    @(posedge sys_clk);
    ev[k] <= 1'b0;
  endtask : pulse
  // tick and read until the masked value shows, bounded
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    logic [31:0] q;
    for (int i = 0; i < 12; i++) begin
      pulse(16);
      rd(a, q);
      if ((q & m) === e) break;
    end
    chk(nm, q & m, e);
    // a poll that used up its bound ends the run
    if ((q & m) !== e) end_of_test();
  endtask : poll
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_reset;
    logic [31:0] q;
    rd(`CTF_OFS_STATUS, q);
    chk("status", q, `CTF_STATUS_RST);
    rd(`CTF_OFS_FLAGS, q);
    chk("flags", q, 32'h0);
    wr(8'h7c, 32'hffff_ffff);
    rd(8'h7c, q);
    chk("spare", q, 32'h0);
    cmp <= 4'h6;
  endtask : t_reset
  // counter, retrigger, wrap and match events pend until a tick; write zero keeps, write one clears
  task automatic t_flags;
    logic [31:0] q;
    int          e;
    int          b;
    for (int k = 0; k < 7; k++) begin
      e = (k < 3) ? 8 + k : k - 3;
      b = (k < 3) ? 2 - k : 13 + k;
      pulse(e);
      rd(`CTF_OFS_FLAGS, q);
      chk("early", q[b], 1'b0);
      poll(`CTF_OFS_FLAGS, 32'h1 << b, 32'h1 << b, "flag");
      wr(`CTF_OFS_FLAGS, ~(32'h1 << b));
      rd(`CTF_OFS_FLAGS, q);
      chk("w0", q[b], 1'b1);
      wr(`CTF_OFS_FLAGS, 32'h1 << b);
      rd(`CTF_OFS_FLAGS, q);
      chk("w1", q[b], 1'b0);
    end
  endtask : t_flags
  // fault pins: state, input, flag, clear refused while pin active
  task automatic t_faults;
    logic [31:0] q;
    int          s;
    for (int j = 0; j < 4; j++) begin
      s = 12 + j;
      wr(`CTF_OFS_CTRL, (j == 0) ? 32'h0000_0200 : 32'h0);
      pins[j] <= 1'b1;
      poll(`CTF_OFS_STATUS, 32'h11 << (8 + j), 32'h11 << (8 + j), "fault");
      poll(`CTF_OFS_FLAGS, 32'h1 << s, 32'h1 << s, "fault flag");
      if (j == 0) chk("halt", counter_halt, 1'b1);
      wr(`CTF_OFS_STATUS, 32'h1 << s);
      rd(`CTF_OFS_STATUS, q);
      chk("held", q[s], 1'b1);
      pins[j] <= 1'b0;
      poll(`CTF_OFS_STATUS, 32'h1 << (8 + j), 32'h0, "pin low");
      if (j < 2) pulse(14 + j);
      else wr(`CTF_OFS_STATUS, 32'h1 << s);
      rd(`CTF_OFS_STATUS, q);
      chk("cleared", q[s], 1'b0);
      chk("release", counter_halt, 1'b0);
      wr(`CTF_OFS_FLAGS, 32'h1 << s);
    end
  endtask : t_faults
  // two captures with no read between, then a value read
  task automatic t_capture;
    logic [31:0] q;
    wr(`CTF_OFS_CTRL, 32'h0000_0001);
    capture_val <= 24'h12_3456;
    pulse(4);
    poll(`CTF_OFS_STATUS, 32'h1 << `CTF_S_CHBV, 32'h1 << `CTF_S_CHBV, "cap valid");
    poll(`CTF_OFS_FLAGS, 32'h1 << `CTF_B_HIT, 32'h1 << `CTF_B_HIT, "cap flag");
    pulse(4);
    poll(`CTF_OFS_FLAGS, 32'h8, 32'h8, "overrun");
    rd(`CTF_OFS_CHVAL0, q);
    chk("cap value", q[23:0], 24'h12_3456);
    rd(`CTF_OFS_FLAGS, q);
    chk("read clear", q[16], 1'b0);
    rd(`CTF_OFS_STATUS, q);
    chk("cap valid clr", q[16], 1'b0);
    wr(`CTF_OFS_FLAGS, 32'h8);
  endtask : t_capture
  // buffer writes under lock, cleared by update, then by write one
  task automatic t_buffers;
    logic [31:0] q;
    wr(`CTF_OFS_CTRL, 32'h0000_0010);
    for (int n = 0; n < 2; n++) begin
      wr(`CTF_OFS_CHBUF0 + 8'h04, 32'h0000_0123);
      wr(`CTF_OFS_PERBUF, 32'h0000_0456);
      wr(`CTF_OFS_WAVEBUF, 32'h0000_0001);
      wr(`CTF_OFS_PATTBUF, 32'h0000_0f0f);
      rd(`CTF_OFS_STATUS, q);
      chk("bv set", q & 32'h0002_00e0, 32'h0002_00e0);
      if (n == 0) pulse(11);
      else wr(`CTF_OFS_STATUS, 32'h0002_00e0);
      poll(`CTF_OFS_STATUS, 32'h0002_00e0, 32'h0, "bv clear");
    end
    // buffer write and locked update on one edge: the set must win
    fork
      wr(`CTF_OFS_PERBUF, 32'h0000_0789);
      pulse(11);
    join
    rd(`CTF_OFS_STATUS, q);
    chk("set wins", q[`CTF_S_PERIOD_BUFFER_VALID], 1'b1);
    // without lock a written one leaves compare buffer valid set
    wr(`CTF_OFS_CTRL, 32'h0000_0000);
    wr(`CTF_OFS_CHBUF0 + 8'h04, 32'h0000_0321);
    wr(`CTF_OFS_STATUS, 32'h0002_0000);
    rd(`CTF_OFS_STATUS, q);
    chk("bv no lock", q[17], 1'b1);
  endtask : t_buffers
  // stop and single-shot update, then ramp bit in each mode except the reserved one
  task automatic t_stop_ramp;
    logic [31:0] q;
    ctf_ramp_t   m [4] = '{CTF_RAMP_SINGLE, CTF_RAMP_ALT_TWO, CTF_RAMP_TWO, CTF_RAMP_TWO};
    for (int k = 0; k < 2; k++) begin
      pulse(13);
      poll(`CTF_OFS_STATUS, 32'h1, 32'h0, "running");
      wr(`CTF_OFS_CTRL, (k == 1) ? 32'h0000_0080 : 32'h0);
      pulse((k == 0) ? 12 : 11);
      poll(`CTF_OFS_STATUS, 32'h1, 32'h1, "stopped");
    end
    for (int k = 0; k < 4; k++) begin
      ramp_b <= (k < 3);
      wr(`CTF_OFS_CTRL, {25'h000_0000, m[k], 5'h00});
      rd(`CTF_OFS_STATUS, q);
      chk("ramp", q[1], k == 1 || k == 2);
      chk("cmp", q[27:24], 4'h6);
    end
  endtask : t_stop_ramp
  // debug halt: forced outputs, clear refused while in debug
  task automatic t_debug;
    logic [31:0] q;
    wr(`CTF_OFS_CTRL, 32'h005f_0100);
    dbg <= 1'b1;
    poll(`CTF_OFS_STATUS, 32'h8, 32'h8, "dbg state");
    poll(`CTF_OFS_FLAGS, 32'h1 << `CTF_B_DBG, 32'h1 << `CTF_B_DBG, "dbg flag");
    chk("dbg halt", counter_halt, 1'b1);
    chk("force en", wave_force_en, 4'hf);
    chk("force val", wave_force_val, 4'h5);
    wr(`CTF_OFS_STATUS, 32'h8);
    rd(`CTF_OFS_STATUS, q);
    chk("dbg held", q[3], 1'b1);
    dbg <= 1'b0;
    wr(`CTF_OFS_STATUS, 32'h8);
    rd(`CTF_OFS_STATUS, q);
    chk("dbg clr", q[3], 1'b0);
    chk("dbg run", counter_halt, 1'b0);
  endtask : t_debug
  // reset, then every scenario in turn
  initial begin
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset();
    t_flags();
    t_faults();
    t_capture();
    t_buffers();
    t_stop_ramp();
    t_debug();
    end_of_test();
  end
endmodule : testbench
bind ctf_flags_status ctf_flags_status_chk u_chk (.sys_clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_dat_o, .wb_ack_o, .ramp_cycle_b, .compare_output_level, .recov_input_a, .recov_input_b,
  .nonrecov_input_zero, .nonrecov_input_one);
`default_nettype wire
